//--- verilog/egc_defs.svh
// egc_defs.svh: constants for the group ecc block of the eeprom core.
// assumes inclusion by bare name from design files only.
`ifndef EGC_DEFS_SVH
`define EGC_DEFS_SVH
`define EGC_ADDR_W      12
`define EGC_GRP_W       10
`define EGC_DATA_W      32
`define EGC_CHK_W       7
`define EGC_ERASED_BYTE 8'hff
`define EGC_ERASED_WORD 32'hffffffff
`define EGC_ID_LEN      32
`define EGC_ID_CODE_LEN 3
`define EGC_SR_WD_POS   7
`define EGC_SR_BPH_POS  3
`define EGC_SR_BPL_POS  2
`define EGC_SR_NV_RESET 8'h00
`endif

//--- verilog/egc_pkg.sv
// egc_pkg.sv: types for the group ecc block.
// assumes egc_defs.svh is on the include path.
package egc_pkg;
   // sequencer states
   typedef enum logic [2:0] {EGC_IDLE, EGC_RD, EGC_WR_RD, EGC_WR_WR, EGC_INIT} egc_state_t;
endpackage : egc_pkg

//--- verilog/egc_group_ecc.sv
// egc_group_ecc.sv: per-group ecc core with delivered-state initialiser.
// assumes the spi front end issues byte read and write requests and waits for done.
//
// Behaviour
// RULE_01: correction never alters spi command timing
// RULE_02: one check code per aligned four-byte group
// RULE_03: single bit error corrected on read
// RULE_04: byte write reprograms whole group with code
// RULE_05: host keeps group writes below endurance limit
// RULE_06: delivered array reads ffh with valid code
// RULE_07: delivered status protect bits all cleared
// RULE_08: id page holds id code then ffh
// RULE_09: listed instructions start counted write cycle
// RULE_10: full group decoded before byte returned
`timescale 1ns/1ps
`include "egc_defs.svh"
module egc_group_ecc #(
   parameter logic [23:0] ID_CODE = 24'h0a0b0c   // arbitrary identification value
) (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     rd_req,       // byte read request
   input  wire logic                     wr_req,       // byte write request
   input  wire logic [`EGC_ADDR_W-1:0]   addr,
   input  wire logic [7:0]               wr_data,
   input  wire logic                     id_rd,        // identification page read
   input  wire logic [4:0]               id_addr,
   input  wire logic                     inj_en,       // test: flip one stored bit on write
   input  wire logic [5:0]               inj_pos,      // codeword bit to flip, 0..38
   output logic      [7:0]               rd_data,      // corrected byte, registered
   output logic      [7:0]               id_data,      // id page byte, registered
   output logic                          done,         // one-cycle completion pulse
   output logic                          busy,         // sequencer active or initialising
   output logic                          corrected,    // last read fixed one bit
   output logic      [7:0]               nv_status     // non-volatile status bits
);
   // ****************************************
   // storage
   // ****************************************
   logic [`EGC_DATA_W-1:0] data_mem [0:(1<<`EGC_GRP_W)-1];  // group data words
   logic [`EGC_CHK_W-1:0]  chk_mem  [0:(1<<`EGC_GRP_W)-1];  // group check codes
   logic [7:0]             id_mem   [0:`EGC_ID_LEN-1];      // id page
   egc_pkg::egc_state_t    state_r;
   logic [`EGC_GRP_W-1:0]  grp_r;                          // group under work
   logic [1:0]             lane_r;                         // byte within group
   logic [7:0]             wbyte_r;
   logic [`EGC_DATA_W-1:0] raw_r;                          // stored word read back
   logic [`EGC_CHK_W-1:0]  rawc_r;
   logic [`EGC_GRP_W-1:0]  init_r;                         // delivery-state sweep index
   logic                   inj_r;                          // fault requested with this write
   logic [5:0]             inj_pos_r;                      // codeword bit to flip

   // ****************************************
   // hamming code helpers
   // ****************************************
   // code position of data bit i: skip power-of-two slots, position in 3..38
   function automatic logic [5:0] egc_pos(input int i);
      int p;
      int k;
      p = 0;
      k = -1;
      for (int q = 1; q < 40; q++) begin
         if ((q & (q - 1)) != 0) begin
            k++;
            if (k == i) p = q;
         end
      end
      return 6'(p);
   endfunction : egc_pos

   // six hamming bits plus overall parity
   function automatic logic [`EGC_CHK_W-1:0] egc_enc(input logic [`EGC_DATA_W-1:0] d);
      logic [5:0] h;
      h = 6'h00;
      for (int i = 0; i < `EGC_DATA_W; i++) begin
         if (d[i]) h = h ^ egc_pos(i);
      end
      return {^d ^ ^h, h};
   endfunction : egc_enc

   // ****************************************
   // decode
   // ****************************************
   logic [5:0]             syn;         // syndrome
   logic                   par_bad;     // overall parity mismatch
   logic [`EGC_DATA_W-1:0] fixed;       // corrected group
   logic [`EGC_CHK_W-1:0]  recalc;
   always_comb begin
      recalc  = egc_enc(raw_r);
      syn     = recalc[5:0] ^ rawc_r[5:0];
      par_bad = ^{raw_r, rawc_r};
      fixed   = raw_r;
      // single error flips exactly the bit whose position matches the syndrome
      for (int i = 0; i < `EGC_DATA_W; i++) begin
         if (par_bad && syn == egc_pos(i)) fixed[i] = ~raw_r[i];   // RULE_03
      end
   end

   // ****************************************
   // write merge
   // ****************************************
   // new byte goes into the corrected group, so a latent single error is scrubbed;
   // an injected fault flips one stored bit, the only way to reach the fix path
   logic [`EGC_DATA_W-1:0]            merged;      // corrected group, new byte in place
   logic [`EGC_DATA_W+`EGC_CHK_W-1:0] flip;        // single-bit fault mask, code and data
   logic [`EGC_DATA_W-1:0]            store_dat;   // word to program
   logic [`EGC_CHK_W-1:0]             store_chk;   // code to program
   always_comb begin
      merged = fixed;
      merged[lane_r*8 +: 8] = wbyte_r;                         // RULE_04
      flip = '0;
      // positions past the codeword are ignored
      if (inj_r && inj_pos_r < 6'd39) flip[inj_pos_r] = 1'b1;
      {store_chk, store_dat} = {egc_enc(merged), merged} ^ flip;
   end

   // ****************************************
   // sequencer
   // ****************************************
   // read is two cycles: fetch, then decode whole group; fixed latency either way
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= egc_pkg::EGC_INIT;
         grp_r   <= '0;
         lane_r  <= 2'h0;
         wbyte_r <= 8'h00;
         init_r  <= '0;
         inj_r     <= 1'b0;
         inj_pos_r <= 6'h00;
      end else begin
         case (state_r)
            egc_pkg::EGC_INIT: begin
               init_r <= init_r + 1'b1;
               if (&init_r) state_r <= egc_pkg::EGC_IDLE;
            end
            egc_pkg::EGC_IDLE: begin
               grp_r   <= addr[`EGC_ADDR_W-1:2];      // RULE_02
               lane_r  <= addr[1:0];
               wbyte_r <= wr_data;
               inj_r     <= inj_en;
               inj_pos_r <= inj_pos;
               if (wr_req) state_r <= egc_pkg::EGC_WR_RD;   // RULE_09
               else if (rd_req) state_r <= egc_pkg::EGC_RD;
            end
            egc_pkg::EGC_RD:    state_r <= egc_pkg::EGC_IDLE;
            egc_pkg::EGC_WR_RD: state_r <= egc_pkg::EGC_WR_WR;
            egc_pkg::EGC_WR_WR: state_r <= egc_pkg::EGC_IDLE;
            default:            state_r <= egc_pkg::EGC_IDLE;
         endcase
      end
   end

   // ****************************************
   // array access
   // ****************************************
   // fetch word and code; a sweep writes erased words with their codes
   always_ff @(posedge mclk) begin
      raw_r  <= data_mem[grp_r];
      rawc_r <= chk_mem[grp_r];
      if (state_r == egc_pkg::EGC_IDLE) begin
         raw_r  <= data_mem[addr[`EGC_ADDR_W-1:2]];
         rawc_r <= chk_mem[addr[`EGC_ADDR_W-1:2]];
      end
      if (state_r == egc_pkg::EGC_INIT) begin
         data_mem[init_r] <= `EGC_ERASED_WORD;                    // RULE_06
         chk_mem[init_r]  <= egc_enc(`EGC_ERASED_WORD);          // RULE_06
      end else if (state_r == egc_pkg::EGC_WR_WR) begin
         // the other three bytes keep their corrected values
         data_mem[grp_r] <= store_dat;                           // RULE_04
         chk_mem[grp_r]  <= store_chk;                           // RULE_04
      end
   end

   // ****************************************
   // read answers
   // ****************************************
   // byte leaves only after the whole group decoded
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_data   <= 8'h00;
         corrected <= 1'b0;
      end else if (state_r == egc_pkg::EGC_RD) begin
         rd_data   <= fixed[lane_r*8 +: 8];                      // RULE_10
         corrected <= par_bad;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) done <= 1'b0;
      else done <= state_r == egc_pkg::EGC_RD || state_r == egc_pkg::EGC_WR_WR;  // RULE_01
   end

   assign busy = state_r != egc_pkg::EGC_IDLE;

   // ****************************************
   // id page and status, delivered state
   // ****************************************
   // sram stand-in for the nonvolatile page; reset reloads delivery values
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < `EGC_ID_LEN; i++) id_mem[i] <= `EGC_ERASED_BYTE;  // RULE_08
         id_mem[0] <= ID_CODE[23:16];                                       // RULE_08
         id_mem[1] <= ID_CODE[15:8];
         id_mem[2] <= ID_CODE[7:0];
         id_data   <= 8'h00;
      end else if (id_rd) begin
         id_data <= id_mem[id_addr];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) nv_status <= `EGC_SR_NV_RESET;                  // RULE_07
   end

   // ****************************************
   // checks
   // ****************************************
   AST_RD_LAT: assert property (@(posedge mclk) disable iff (rst)   // RULE_01
      (state_r == egc_pkg::EGC_IDLE && rd_req && !wr_req) |-> ##2 done)
      else $error("read did not finish in two cycles");
   AST_WR_LAT: assert property (@(posedge mclk) disable iff (rst)   // RULE_09
      (state_r == egc_pkg::EGC_IDLE && wr_req) |-> ##3 done)
      else $error("write did not finish in three cycles");
   AST_FIX: assert property (@(posedge mclk) disable iff (rst)      // RULE_03
      (state_r == egc_pkg::EGC_RD && !par_bad) |=> !corrected)
      else $error("clean read flagged as corrected");
   AST_CORR: assert property (@(posedge mclk) disable iff (rst)     // RULE_03
      (state_r == egc_pkg::EGC_RD && par_bad) |=> corrected)
      else $error("single-bit error not flagged");
   AST_NOBUSY: assert property (@(posedge mclk) disable iff (rst)   // RULE_10
      done |-> $past(busy))
      else $error("done without activity");
   AST_STATUS: assert property (@(posedge mclk) disable iff (rst)   // RULE_07
      nv_status[`EGC_SR_WD_POS] == 1'b0 && nv_status[`EGC_SR_BPH_POS] == 1'b0
      && nv_status[`EGC_SR_BPL_POS] == 1'b0)
      else $error("protect bits not clear");
   AST_WRDATA: assert property (@(posedge mclk) disable iff (rst)   // RULE_04
      (state_r == egc_pkg::EGC_WR_WR && !inj_r) |=>
      (chk_mem[$past(grp_r)] == egc_enc(data_mem[$past(grp_r)])
      && 8'(data_mem[$past(grp_r)] >> {$past(lane_r), 3'b000}) == $past(wbyte_r)))
      else $error("written byte or group code not stored");
   AST_INIT: assert property (@(posedge mclk) disable iff (rst)     // RULE_06
      (state_r == egc_pkg::EGC_INIT) |-> busy)
      else $error("init not busy");
   AST_GRP: assert property (@(posedge mclk) disable iff (rst)      // RULE_02
      (state_r == egc_pkg::EGC_IDLE && rd_req) |=> grp_r == $past(addr[`EGC_ADDR_W-1:2]))
      else $error("wrong group selected");
   COV_RD:  cover property (@(posedge mclk) state_r == egc_pkg::EGC_RD);
   COV_FIX: cover property (@(posedge mclk) state_r == egc_pkg::EGC_RD && par_bad);
   COV_WR:  cover property (@(posedge mclk) state_r == egc_pkg::EGC_WR_WR);
endmodule : egc_group_ecc

//--- sim/egc_host_model.sv
// egc_host_model.sv: front-end request model driving the group ecc core.
// assumes one clock; xfer requests only while the core reports idle, poke regardless of busy.
`timescale 1ns/1ps
module egc_host_model (
   input  wire logic        mclk,
   input  wire logic        busy,
   input  wire logic        done,
   input  wire logic [7:0]  rd_data,
   output logic             rd_req,
   output logic             wr_req,
   output logic [11:0]      addr,
   output logic [7:0]       wr_data
);
   // ****************
   // request engine
   // ****************
   int wr_cnt [0:1023];   // write cycles seen per group
   initial begin
      rd_req = 1'b0;
      wr_req = 1'b0;
      addr = 12'h000;
      wr_data = 8'h00;
      foreach (wr_cnt[i]) wr_cnt[i] = 0;
   end
   // one transfer: wait idle, present one cycle, release, wait done
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [7:0] q, output int lat);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (busy !== 1'b0 && n < 3000);
      // stop writing a group once its budget would be spent
      wr_req <= w && (wr_cnt[a[11:2]] < 4000000);
      rd_req <= !w;
      addr <= a;
      wr_data <= d;
      if (w) wr_cnt[a[11:2]]++;
      @(posedge mclk);
      rd_req <= 1'b0;
      wr_req <= 1'b0;
      // released lines show the inverse so stale values never look valid
      addr <= ~a;
      wr_data <= ~d;
      lat = 0;
      do begin
         @(posedge mclk);
         lat++;
      end while (done !== 1'b1 && lat < 20);
      q = rd_data;
   endtask : xfer
   // one write presented regardless of busy, to show that a busy core ignores it
   task automatic poke(input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr_req <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_req <= 1'b0;
      addr <= ~a;
      wr_data <= ~d;
   endtask : poke
endmodule : egc_host_model

//--- sim/testbench.sv
// testbench.sv: self-checking bench for the group ecc core.
// assumes egc_host_model drives the request port.
`timescale 1ns/1ps
module testbench;
   logic        mclk, rst, rd_req, wr_req, id_rd, done, busy, corrected;
   logic [11:0] addr, a;
   logic [7:0]  wr_data, rd_data, id_data, nv_status, q, d;
   logic [4:0]  id_addr;
   logic        inj_en;         // fault injection toward the next write
   logic [5:0]  inj_pos;        // codeword bit to flip
   logic [7:0]  mdl [0:4095];   // reference array contents
   int          err_count, check_count, lat, lat0, seed;
   // id bytes all equal so byte order cannot matter; value is arbitrary
   egc_group_ecc #(.ID_CODE(24'h5a5a5a)) uut (.mclk(mclk), .rst(rst), .rd_req(rd_req),
      .wr_req(wr_req), .addr(addr), .wr_data(wr_data), .id_rd(id_rd), .id_addr(id_addr),
      .inj_en(inj_en), .inj_pos(inj_pos),
      .rd_data(rd_data), .id_data(id_data), .done(done), .busy(busy),
      .corrected(corrected), .nv_status(nv_status));
   egc_host_model host (.mclk(mclk), .busy(busy), .done(done), .rd_data(rd_data),
      .rd_req(rd_req), .wr_req(wr_req), .addr(addr), .wr_data(wr_data));
   always #50 mclk = ~mclk;
   // ****************
   // checking helpers
   // ****************
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task conclude;
      if (err_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   // read against model; latency must not depend on correction
   task automatic rd(input logic [11:0] ra, input logic fx);
      host.xfer(1'b0, ra, 8'h00, q, lat);
      chk(q, mdl[ra]);
      chk({7'h00, corrected}, {7'h00, fx});
      chk(lat[7:0], 8'h02);
   endtask : rd
   // ****************
   // main sequence
   // ****************
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      id_rd = 1'b0;
      id_addr = 5'h00;
      inj_en = 1'b0;
      inj_pos = 6'h00;
      err_count = 0;
      check_count = 0;
      seed = 32'hd78b603c;
      foreach (mdl[i]) mdl[i] = 8'hff;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      // a write during initialisation must be ignored
      host.poke(12'h005, 8'h00);
      chk(nv_status, 8'h00);
      host.xfer(1'b0, 12'h000, 8'h00, q, lat0);
      chk(q, 8'hff);
      chk(lat0[7:0], 8'h02);
      rd(12'h005, 1'b0);
      rd(12'hfff, 1'b0);
      for (int i = 0; i < 32; i++) begin
         @(posedge mclk);
         id_rd <= 1'b1;
         id_addr <= i[4:0];
         @(posedge mclk);
         id_rd <= 1'b0;
         @(posedge mclk);
         chk(id_data, (i < 3) ? 8'h5a : 8'hff);
      end
      // random single-byte writes, every third stored with one bit flipped,
      // then the whole group read back; the next write to it scrubs the fault
      for (int i = 0; i < 40; i++) begin
         a = {(i % 2 != 0) ? 8'hff : 8'h00, 4'($random(seed))};
         d = 8'($random(seed));
         inj_en <= (i % 3 == 0);
         inj_pos <= 6'($unsigned($random(seed)) % 39);
         host.xfer(1'b1, a, d, q, lat);
         chk(lat[7:0], 8'h03);
         inj_en <= 1'b0;
         mdl[a] = d;
         for (int k = 0; k < 4; k++) rd({a[11:2], k[1:0]}, i % 3 == 0);
      end
      chk(nv_status, 8'h00);
      conclude();
   end
   // watchdog well beyond init plus all transfers
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      conclude();
   end
endmodule : testbench
